// ---- include/icf_defines.vh ----
// Operation
// - every flag sets on its event regardless of enable or global enable bits
// - priority off: main bit 7 enables all unmasked sources, zero blocks all
// - priority on: main bit 7 is high-priority enable; zero blocks everything
// - priority off: main bit 6 gates all peripheral sources
// - priority on: main bit 6 gates all low-priority sources
// - main bit 5 timer-0 overflow enable, bit 2 its flag set on overflow
// - main bit 4 external pin a enable, bit 1 flag on selected edge
// - main bit 0 port-change flag on upper four port pins; enable bit 3
// - flag keeps setting while port mismatch persists; software reads port first
// - event flags stay set until software writes zero
// - second control bit 7 disables every port pull-up, else direction decides
// - second control bits 6..3 pick edges of pins a..d, one means rising
// - second control bits 2,1,0 prioritise timer-0, pin d, port change
// - third control bits 7,6 prioritise pins c and b
// - third control bits 5..3 enable pins d,c,b; bits 2..0 their flags
// - peripheral flag bit 7 unimplemented, reads zero
// - peripheral flag bit 6 sets on conversion done, held until cleared
// - serial receive flag follows full receive buffer, read only
// - serial transmit flag follows empty transmit buffer, read only
// - peripheral flag bits 3..0: sync serial, gate, timer-2 match, timer-1
// - six peripheral flag registers exist; the first is held here
// - priority feature only while priority enable is one
// - request vectors to 0008h high or 0018h low
// - taking an interrupt clears that level's enable; return sets it again
// - low-priority request needs both low and high global enables
`ifndef ICF_DEFINES_VH
`define ICF_DEFINES_VH
`define ICF_ADDR_W        3
`define ICF_OFF_MAIN      3'h0
`define ICF_OFF_EDGE      3'h1
`define ICF_OFF_EXT       3'h2
`define ICF_OFF_PFLAG     3'h3
`define ICF_OFF_CTRL      3'h4
`define ICF_RST_MAIN      8'h00
`define ICF_RST_EDGE      8'hFF
`define ICF_RST_EXT       8'hC0
`define ICF_PFLAG_WMASK   8'h4F
`define ICF_VEC_HIGH      16'h0008
`define ICF_VEC_LOW       16'h0018
`define ICF_PORT_LO       4
`define ICF_PORT_HI       7
`endif

// ---- hdl/icf_edge_det.v ----
`timescale 1ns/1ps
`include "icf_defines.vh"
module icf_edge_det #(
    parameter N = 4
) (
    input  wire         core_clk,
    input  wire         nrst,
    input  wire [N-1:0] pinAsync,
    input  wire [N-1:0] riseSel,
    output wire [N-1:0] edgeHit,
    output wire [N-1:0] pinSync
);
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_pin
            reg meta_q;
            reg sync_q;
            reg last_q;
            always @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                    last_q <= 1'b0;
                end else begin
                    meta_q <= pinAsync[i];
                    sync_q <= meta_q;
                    last_q <= sync_q;
                end
            end
            // selected edge only
            assign edgeHit[i] = riseSel[i] ? (sync_q & ~last_q) : (~sync_q & last_q);
            assign pinSync[i] = sync_q;
        end
    endgenerate
endmodule // icf_edge_det

// ---- hdl/icf_intctl.v ----
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "icf_defines.vh"
module icf_intctl (
    input  wire        core_clk,
    input  wire        nrst,
    input  wire [2:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire [3:0]  extPin,
    input  wire [3:0]  portUpperPin,
    input  wire        portRead,
    input  wire [7:0]  portDirIn,
    output wire [7:0]  portPullupOn,
    input  wire        timerZeroOverflow,
    input  wire        conversionDone,
    input  wire        syncSerialDone,
    input  wire        timerOneGate,
    input  wire        timerTwoMatch,
    input  wire        timerOneOverflow,
    input  wire        serialOneRxFull,
    input  wire        serialOneTxEmpty,
    input  wire        periphFlagsOther,
    input  wire        periphEnableOther,
    input  wire        periphPriorityOther,
    input  wire        intAck,
    input  wire        returnFromInterrupt,
    output reg         intRequest,
    output reg  [15:0] intVector
);
    ////////////////////////////////////////////////////////////////////////////
    reg  [7:0] main_q;
    reg  [7:0] edge_q;
    reg  [7:0] ext_q;
    reg  [7:0] pflag_q;
    reg  [7:0] pen_q;
    reg  [7:0] pprio_q;
    reg        prioEn_q;
    reg        ackDone_q;
    reg  [3:0] portLatch_q;
    reg        inSvcHigh_q;
    reg        inSvcLow_q;
    wire [3:0] extHit;
    wire [3:0] extSync;
    wire [3:0] portMeta;
    reg  [3:0] portM_q;
    reg  [3:0] portS_q;
    wire       wrMain;
    wire       wrEdge;
    wire       wrExt;
    wire       wrPflag;
    wire       wrCtrl;
    wire       mismatch;
    wire [7:0] wd;

    // one-cycle answer: waitrequest rises on the first request cycle only
    assign avs_waitrequest = (avs_read | avs_write) & ~ackDone_q;
    wire   accept = (avs_read | avs_write) & ackDone_q;
    assign wd     = avs_writedata[7:0];
    assign wrMain  = accept & avs_write & avs_byteenable[0] & (avs_address == `ICF_OFF_MAIN);
    assign wrEdge  = accept & avs_write & avs_byteenable[0] & (avs_address == `ICF_OFF_EDGE);
    assign wrExt   = accept & avs_write & avs_byteenable[0] & (avs_address == `ICF_OFF_EXT);
    assign wrPflag = accept & avs_write & avs_byteenable[0] & (avs_address == `ICF_OFF_PFLAG);
    assign wrCtrl  = accept & avs_write & avs_byteenable[0] & (avs_address == `ICF_OFF_CTRL);

    ////////////////////////////////////////////////////////////////////////////
    icf_edge_det #(
        .N(4)
    ) u_edge (
        .core_clk (core_clk),
        .nrst     (nrst),
        .pinAsync (extPin),
        .riseSel  ({edge_q[3], edge_q[4], edge_q[5], edge_q[6]}),
        .edgeHit  (extHit),
        .pinSync  (extSync)
    );
    assign portMeta = portUpperPin;

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            portM_q     <= 4'h0;
            portS_q     <= 4'h0;
            portLatch_q <= 4'h0;
            ackDone_q   <= 1'b0;
        end else begin
            portM_q   <= portMeta;
            portS_q   <= portM_q;
            ackDone_q <= (avs_read | avs_write) & ~ackDone_q;
            // port read refreshes the reference value, ending a mismatch
            if (portRead) begin
                portLatch_q <= portS_q;
            end
        end
    end
    assign mismatch = |(portS_q ^ portLatch_q);

    // pull-ups: disable bit overrides, else input direction enables
    assign portPullupOn = edge_q[7] ? 8'h00 : portDirIn;

    ////////////////////////////////////////////////////////////////////////////
    // flags: set term ORed after the software value so the set wins
    wire [2:0] mainSet = {timerZeroOverflow, extHit[0], mismatch};
    wire [2:0] extSet  = {extHit[3], extHit[2], extHit[1]};
    wire [4:0] pfSet   = {conversionDone, 1'b0, syncSerialDone,
                          timerOneGate, timerTwoMatch};
    reg        takeHigh;
    reg        takeLow;

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            main_q   <= `ICF_RST_MAIN;
            edge_q   <= `ICF_RST_EDGE;
            ext_q    <= `ICF_RST_EXT;
            pflag_q  <= 8'h00;
            pen_q    <= 8'h00;
            pprio_q  <= 8'h00;
            prioEn_q <= 1'b0;
        end else begin
            if (wrMain) begin
                main_q <= {wd[7:3], wd[2:0] | mainSet};
            end else begin
                main_q[2:0] <= main_q[2:0] | mainSet;
            end
            // level entry clears its own global enable
            if (takeHigh) begin
                main_q[7] <= 1'b0;
            end else if (takeLow) begin
                main_q[6] <= 1'b0;
            end else if (returnFromInterrupt & inSvcHigh_q) begin
                main_q[7] <= 1'b1;
            end else if (returnFromInterrupt & inSvcLow_q) begin
                main_q[6] <= 1'b1;
            end
            if (wrEdge) begin
                edge_q <= wd;
            end
            if (wrExt) begin
                ext_q <= {wd[7:3], wd[2:0] | extSet};
            end else begin
                ext_q[2:0] <= ext_q[2:0] | extSet;
            end
            if (wrPflag) begin
                pflag_q[6] <= wd[6] | pfSet[4];
                pflag_q[3:0] <= wd[3:0] | {pfSet[2:0], timerOneOverflow};
            end else begin
                pflag_q[6] <= pflag_q[6] | pfSet[4];
                pflag_q[3:0] <= pflag_q[3:0] | {pfSet[2:0], timerOneOverflow};
            end
            pflag_q[7] <= 1'b0;
            pflag_q[5] <= serialOneRxFull;
            pflag_q[4] <= serialOneTxEmpty;
            if (wrCtrl) begin
                prioEn_q <= wd[7];
                pen_q    <= {1'b0, wd[6:0]};
            end
            if (accept & avs_write & avs_byteenable[1] & (avs_address == `ICF_OFF_CTRL)) begin
                pprio_q <= {1'b0, avs_writedata[14:8]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // request combine: core sources, peripheral-first flags, remaining groups
    wire [3:0] coreFire = {main_q[2] & main_q[5], main_q[1] & main_q[4],
                           main_q[0] & main_q[3], 1'b0};
    wire [2:0] extFire  = ext_q[2:0] & ext_q[5:3];
    wire [6:0] pFire    = pflag_q[6:0] & pen_q[6:0];
    wire       otherFire = periphFlagsOther & periphEnableOther;
    // pin a always high priority when priority feature on
    wire hiCore = (coreFire[3] & edge_q[2]) | coreFire[2] | (coreFire[1] & edge_q[0]) |
                  (extFire[2] & edge_q[1]) | (extFire[1] & ext_q[7]) |
                  (extFire[0] & ext_q[6]);
    wire loCore = (coreFire[3] & ~edge_q[2]) | (coreFire[1] & ~edge_q[0]) |
                  (extFire[2] & ~edge_q[1]) | (extFire[1] & ~ext_q[7]) |
                  (extFire[0] & ~ext_q[6]);
    wire hiPer  = |(pFire & pprio_q[6:0]) | (otherFire & periphPriorityOther);
    wire loPer  = |(pFire & ~pprio_q[6:0]) | (otherFire & ~periphPriorityOther);
    wire anyCore = |coreFire | |extFire;
    wire anyPer  = |pFire | otherFire;

    reg reqHigh;
    reg reqLow;
    always @* begin
        reqHigh = 1'b0;
        reqLow  = 1'b0;
        if (prioEn_q) begin
            reqHigh = main_q[7] & (hiCore | hiPer);
            // low level also needs high enable
            reqLow  = main_q[7] & main_q[6] & (loCore | loPer) & ~inSvcHigh_q;
        end else begin
            reqHigh = main_q[7] & (anyCore | (main_q[6] & anyPer));
        end
        takeHigh = intAck & reqHigh;
        takeLow  = intAck & ~reqHigh & reqLow;
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            intRequest  <= 1'b0;
            intVector   <= `ICF_VEC_HIGH;
            inSvcHigh_q <= 1'b0;
            inSvcLow_q  <= 1'b0;
        end else begin
            intRequest <= (reqHigh | reqLow) & ~intAck;
            intVector  <= reqHigh ? `ICF_VEC_HIGH : (prioEn_q ? `ICF_VEC_LOW : `ICF_VEC_HIGH);
            if (takeHigh) begin
                inSvcHigh_q <= 1'b1;
            end else if (returnFromInterrupt & inSvcHigh_q) begin
                inSvcHigh_q <= 1'b0;
            end
            if (takeLow) begin
                inSvcLow_q <= 1'b1;
            end else if (returnFromInterrupt & ~inSvcHigh_q) begin
                inSvcLow_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            avs_readdata <= 32'h0000_0000;
        // loaded in the wait cycle so the word already stands at the accepting edge
        end else if (avs_read & ~ackDone_q) begin
            case (avs_address)
                `ICF_OFF_MAIN:  avs_readdata <= {24'h000000, main_q};
                `ICF_OFF_EDGE:  avs_readdata <= {24'h000000, edge_q};
                `ICF_OFF_EXT:   avs_readdata <= {24'h000000, ext_q};
                `ICF_OFF_PFLAG: avs_readdata <= {24'h000000, pflag_q};
                `ICF_OFF_CTRL:  avs_readdata <= {16'h0000, pprio_q, prioEn_q, pen_q[6:0]};
                default:        avs_readdata <= 32'h0000_0000;
            endcase
        end
    end
    // unused sync view kept for debug-free structure
    wire unusedSync = |extSync;
endmodule // icf_intctl

// ---- dv/icf_intctl_monitor.sv ----
`timescale 1ns/1ps
module icf_intctl_monitor (
    input logic        core_clk,
    input logic        nrst,
    input logic [2:0]  avs_address,
    input logic        avs_read,
    input logic        avs_write,
    input logic [31:0] avs_writedata,
    input logic [3:0]  avs_byteenable,
    input logic [31:0] avs_readdata,
    input logic        avs_waitrequest,
    input logic [7:0]  portDirIn,
    input logic [7:0]  portPullupOn,
    input logic        serialOneRxFull,
    input logic        serialOneTxEmpty,
    input logic        intAck,
    input logic        intRequest,
    input logic [15:0] intVector
);
    logic pullOff_q;
    wire  wLand = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire  rLand = avs_read && !avs_waitrequest;
    // shadow of the pull-up disable bit; edge register resets to ones
    always @(posedge core_clk or negedge nrst)
        if (!nrst) pullOff_q <= 1'b1;
        else if (wLand && avs_address == 3'h1) pullOff_q <= avs_writedata[7];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////
    AST_WAIT_FIRST: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("request answered without wait state");
    AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait state longer than one cycle");
    AST_PF_BIT7: assert property (rLand && avs_address == 3'h3 |-> !avs_readdata[7])
        else $error("unimplemented flag bit read as one");
    AST_SERIAL: assert property (rLand && avs_address == 3'h3 |->
        avs_readdata[5:4] == $past({serialOneRxFull, serialOneTxEmpty}, 2))
        else $error("serial flags do not follow buffers");
    AST_UNMAPPED: assert property (rLand && avs_address > 3'h4 |-> avs_readdata == 32'h0)
        else $error("unmapped index returned data");
    AST_PULLUP: assert property (portPullupOn == (pullOff_q ? 8'h00 : portDirIn))
        else $error("pull-up enables wrong");
    AST_VECTOR: assert property (intRequest |-> intVector inside {16'h0008, 16'h0018})
        else $error("request with bad vector");
    AST_ACK_DROP: assert property (intAck |-> ##[1:2] !intRequest)
        else $error("request stays after acknowledge");
    AST_GLOBAL_OFF: assert property (wLand && avs_address == 3'h0 && !avs_writedata[7]
        |-> ##[1:3] !intRequest)
        else $error("request with global enable clear");
    cover property (intRequest && intVector == 16'h0008);
    cover property (intRequest && intVector == 16'h0018);
    cover property (intAck);
endmodule // icf_intctl_monitor

bind icf_intctl icf_intctl_monitor icf_intctl_monitor_inst (
    .core_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .portDirIn, .portPullupOn, .serialOneRxFull,
    .serialOneTxEmpty, .intAck, .intRequest, .intVector
);

// ---- dv/icf_cpu_model.sv ----
`timescale 1ns/1ps
module icf_cpu_model (
    input  logic        core_clk,
    input  logic        nrst,
    input  logic        intRequest,
    input  logic [15:0] intVector,
    input  logic [3:0]  ackDly,
    input  logic        retReq,
    output logic        intAck,
    output logic        returnFromInterrupt,
    output logic        busy,
    output logic [15:0] takenVec
);
    logic [3:0] wait_q;
    // takes a request seen for ackDly+1 cycles, returns only when told
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            {intAck, returnFromInterrupt, busy, wait_q, takenVec} <= '0;
        end else begin
            intAck <= 1'b0;
            returnFromInterrupt <= retReq && busy;
            if (retReq) busy <= 1'b0;
            wait_q <= 4'h0;
            if (intRequest && !busy && !intAck) begin
                wait_q <= wait_q + 4'h1;
                if (wait_q == ackDly) begin
                    intAck <= 1'b1;
                    busy <= 1'b1;
                    takenVec <= intVector;
                end
            end
        end
    end
endmodule // icf_cpu_model

// ---- dv/icf_intctl_test.sv ----
`timescale 1ns/1ps
module icf_intctl_test;
    logic        core_clk, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [2:0]  avs_address = 3'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic        avs_waitrequest, intAck, returnFromInterrupt, intRequest, busy;
    logic [3:0]  extPin = 4'h0, portUpperPin = 4'h0, ackDly = 4'h0;
    logic [7:0]  portDirIn = 8'hA5, portPullupOn, evt = 8'h00, q;
    logic        serialOneRxFull = 1'b0, serialOneTxEmpty = 1'b1;
    logic [15:0] intVector, takenVec;
    int          n_errors = 0, n_tests = 0;
    logic [7:0]  icf_rst [0:5] = '{8'h00, 8'hFF, 8'hC0, 8'h10, 8'h00, 8'h00};
    icf_intctl icf_intctl_inst (.core_clk, .nrst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .extPin,
        .portUpperPin, .portRead(evt[6]), .portDirIn, .portPullupOn,
        .timerZeroOverflow(evt[0]), .conversionDone(evt[5]), .syncSerialDone(evt[4]),
        .timerOneGate(evt[3]), .timerTwoMatch(evt[2]), .timerOneOverflow(evt[1]),
        .serialOneRxFull, .serialOneTxEmpty, .periphFlagsOther(1'b0),
        .periphEnableOther(1'b0), .periphPriorityOther(1'b0), .intAck,
        .returnFromInterrupt, .intRequest, .intVector);
    icf_cpu_model icf_cpu_model_inst (.core_clk, .nrst, .intRequest, .intVector, .ackDly,
        .retReq(evt[7]), .intAck, .returnFromInterrupt, .busy, .takenVec);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(string n, logic [15:0] got, logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", n, exp, got);
        end
    endtask
    task automatic print_verdict;
        if (n_errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // answer taken at the rising edge where waitrequest is seen low
    task automatic bus(logic w, logic [2:0] a, logic [7:0] d);
        logic ws = 1'b1;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= !w;
        for (int k = 0; k < 20 && ws; k++) begin
            @(posedge core_clk);
            ws = avs_waitrequest;
            q = avs_readdata[7:0];
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (ws) n_errors++;
        if (ws) print_verdict;
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(logic [2:0] a, logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk($sformatf("reg%0d", a), q, e);
    endtask
    task automatic idle(int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic pulse(logic [7:0] m);
        @(posedge core_clk);
        evt <= m;
        @(posedge core_clk);
        evt <= 8'h00;
    endtask
    task automatic take(logic [15:0] v);
        for (int k = 0; k < 40 && !busy; k++) @(negedge core_clk);
        if (!busy) n_errors++;
        if (!busy) print_verdict;
        @(posedge core_clk);
        chk("vector", takenVec, v);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        wr(3'h5, 8'hFF);
        foreach (icf_rst[i]) rd(3'(i), icf_rst[i]);
        pulse(8'h3F);
        rd(0, 8'h04);
        rd(3, 8'h5F);
        wr(3, 8'hFF);
        rd(3, 8'h5F);
        wr(3, 8'h00);
        rd(3, 8'h10);
        serialOneRxFull <= 1'b1;
        serialOneTxEmpty <= 1'b0;
        idle(3);
        wr(3, 8'h00);
        rd(3, 8'h20);
        // hardware set must win over a clear landing in the same cycle
        fork
            wr(0, 8'h00);
            begin
                idle(2);
                evt <= 8'h01;
                idle(1);
                evt <= 8'h00;
            end
        join
        rd(0, 8'h04);
        wr(0, 8'h00);
        wr(1, 8'h28);
        idle(1);
        chk("pullup", portPullupOn, portDirIn);
        extPin <= 4'hF;
        idle(5);
        rd(2, 8'hC5);
        extPin <= 4'h0;
        idle(5);
        rd(0, 8'h02);
        rd(2, 8'hC7);
        wr(2, 8'hC0);
        portUpperPin <= 4'h8;
        idle(5);
        rd(0, 8'h03);
        wr(0, 8'h00);
        rd(0, 8'h01);
        pulse(8'h40);
        idle(2);
        wr(0, 8'h00);
        rd(0, 8'h00);
        wr(0, 8'h20);
        pulse(8'h01);
        idle(6);
        chk("request", intRequest, 1'b0);
        wr(0, 8'hA0);
        pulse(8'h01);
        take(16'h0008);
        rd(0, 8'h24);
        wr(0, 8'h20);
        pulse(8'h80);
        idle(2);
        rd(0, 8'hA0);
        wr(4, 8'h40);
        wr(0, 8'h80);
        pulse(8'h20);
        idle(6);
        chk("request", intRequest, 1'b0);
        wr(0, 8'hC0);
        take(16'h0008);
        wr(3, 8'h00);
        pulse(8'h80);
        wr(4, 8'h80);
        wr(0, 8'h60);
        pulse(8'h01);
        idle(6);
        chk("request", intRequest, 1'b0);
        ackDly <= 4'h5;
        wr(0, 8'hE4);
        take(16'h0018);
        rd(0, 8'hA4);
        print_verdict;
    end
endmodule // icf_intctl_test
